// ===== lmsc_code_mem.sv
// Per-LED current-code memory, twelve matrix entries plus four direct entries.
// Write port from configuration; registered read port used by the scan logic.
`timescale 1ns/1ps
module lmsc_code_mem #(
    parameter int DEPTH = 16
) (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       wrEn,
    input  wire logic [3:0] wrAddr,
    input  wire logic [7:0] wrData,
    input  wire logic [3:0] rdAddr,
    output logic      [7:0] rdData_q
);
    logic [7:0] mem_q [DEPTH];

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= lmsc_pkg::CODE_RESET;
            end
            rdData_q <= lmsc_pkg::CODE_RESET;
        end else begin
            if (wrEn) begin
                mem_q[wrAddr] <= wrData;
            end
            rdData_q <= mem_q[rdAddr];
        end
    end
endmodule : lmsc_code_mem

// ===== lmsc_led_array.sv
// Behavioural model of the twelve-LED matrix on the four output pins.
// Assumes an LED lights only while its anode switch and its cathode sink are on.
`timescale 1ns/1ps
module lmsc_led_array (
    input  wire logic [3:0]  scanSwitchEn,
    input  wire logic [3:0]  sinkEn,
    output logic      [11:0] ledLit
);
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            for (int y = 0; y < 3; y++) begin
                ledLit[k*3+y] = scanSwitchEn[k] & sinkEn[(k+1+y)%4];
            end
        end
    end
endmodule : lmsc_led_array

// ===== lmsc_pkg.sv
// Shared constants for the LED matrix scan controller.
// Assumes a 25 MHz reference clock; all timing counts derive from it.
package lmsc_pkg;
    localparam int REF_CLK_KHZ      = 25000;
    // Times in nanoseconds, as specified.
    localparam int DIM_24K_NS       = 42000;
    localparam int DIM_12K_NS       = 84000;
    localparam int BLANK_SHORT_NS   = 1000;
    localparam int BLANK_LONG_NS    = 2000;
    // Exact cycle counts; 40 ns divides every figure.
    localparam int DIM_24K_CYC      = (DIM_24K_NS * (REF_CLK_KHZ / 1000) + 999) / 1000;
    localparam int DIM_12K_CYC      = (DIM_12K_NS * (REF_CLK_KHZ / 1000) + 999) / 1000;
    localparam int BLANK_SHORT_CYC  = (BLANK_SHORT_NS * (REF_CLK_KHZ / 1000) + 999) / 1000;
    localparam int BLANK_LONG_CYC   = (BLANK_LONG_NS * (REF_CLK_KHZ / 1000) + 999) / 1000;
    localparam int CNT_W            = 12;
    // Boost pass-through thresholds in percent of target.
    localparam int PASS_ENTER_PCT   = 101;
    localparam int PASS_EXIT_PCT    = 97;
    // Drive mode encodings.
    localparam logic [2:0] MODE_DIRECT   = 3'h0;
    localparam logic [2:0] MODE_MIX_BASE = 3'h4;
    localparam logic [7:0] CODE_RESET    = 8'h80;
    localparam logic       RANGE_RESET   = 1'b0;
    localparam int NUM_PINS         = 4;
    localparam int NUM_LEDS         = 12;
    typedef enum logic [1:0] {
        PH_DIM   = 2'b01,
        PH_BLANK = 2'b10
    } lmsc_phase_t;
endpackage : lmsc_pkg

// ===== lmsc_scan_ctrl.sv
// Scan sequencer: slot timing, scan switch and sink enables, clamp control,
// boost pass-through hysteresis, current range and code lookup.
// Assumes configuration ports are static or change with software sequencing.
`timescale 1ns/1ps
module lmsc_scan_ctrl (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic [2:0] driveMode,
    input  wire logic [7:0] scanOrder,
    input  wire logic [3:0] directSelect,
    input  wire logic       pwmFreqSel,
    input  wire logic       gapSel,
    input  wire logic       clampDisable,
    input  wire logic       clampTimingSel,
    input  wire logic [1:0] clampLevelSel,
    input  wire logic       globalRange,
    input  wire logic [3:0] pwmOn,
    input  wire logic       codeWrEn,
    input  wire logic [3:0] codeWrAddr,
    input  wire logic [7:0] codeWrData,
    input  wire logic [7:0] outputPct,
    output logic      [3:0] scanSwitchEn_q,
    output logic      [3:0] sinkEn_q,
    output logic      [3:0] clampEn_q,
    output logic      [1:0] clampLevel_q,
    output logic            fullScaleHigh_q,
    output logic            passThrough_q,
    output logic      [1:0] activePin_q,
    output logic      [7:0] ledCode_q,
    output logic            frameStart_q
);
    localparam logic [lmsc_pkg::CNT_W-1:0] DIM24  = lmsc_pkg::CNT_W'(lmsc_pkg::DIM_24K_CYC);
    localparam logic [lmsc_pkg::CNT_W-1:0] DIM12  = lmsc_pkg::CNT_W'(lmsc_pkg::DIM_12K_CYC);
    localparam logic [lmsc_pkg::CNT_W-1:0] BLK1   = lmsc_pkg::CNT_W'(lmsc_pkg::BLANK_SHORT_CYC);
    localparam logic [lmsc_pkg::CNT_W-1:0] BLK2   = lmsc_pkg::CNT_W'(lmsc_pkg::BLANK_LONG_CYC);
    localparam logic [7:0]                 PENTER = 8'(lmsc_pkg::PASS_ENTER_PCT);
    localparam logic [7:0]                 PEXIT  = 8'(lmsc_pkg::PASS_EXIT_PCT);

    // Number of scans per mode; zero means direct drive.
    function automatic logic [2:0] scansOf(input logic [2:0] m);
        logic [2:0] n;
        n = 3'h0;
        if (m > lmsc_pkg::MODE_MIX_BASE) begin
            n = m - lmsc_pkg::MODE_MIX_BASE;
        end else begin
            n = m;
        end
        return n;
    endfunction : scansOf

    lmsc_pkg::lmsc_phase_t phase_q;
    lmsc_pkg::lmsc_phase_t phase_d;
    logic [lmsc_pkg::CNT_W-1:0] cnt_q;
    logic [lmsc_pkg::CNT_W-1:0] cnt_d;
    logic [1:0]                 slot_q;
    logic [1:0]                 slot_d;

    wire logic [2:0] scanCount = scansOf(driveMode);
    wire logic       isDirect  = (driveMode == lmsc_pkg::MODE_DIRECT);
    wire logic       isMix     = (driveMode > lmsc_pkg::MODE_MIX_BASE);
    wire logic [lmsc_pkg::CNT_W-1:0] dimLen   = pwmFreqSel ? DIM12 : DIM24;
    wire logic [lmsc_pkg::CNT_W-1:0] blankLen = gapSel ? BLK2 : BLK1;
    wire logic [1:0] lastSlot = 2'(scanCount - 3'h1);
    wire logic [1:0] curPin   = scanOrder[2*slot_q +: 2];
    wire logic       dimDone  = (phase_q == lmsc_pkg::PH_DIM) && (cnt_q == dimLen - 1'b1);
    wire logic       blkDone  = (phase_q == lmsc_pkg::PH_BLANK) && (cnt_q == blankLen - 1'b1);
    wire logic       inDim    = (phase_q == lmsc_pkg::PH_DIM);
    wire logic [3:0] pinOneHot = 4'h1 << curPin;
    // Direct outputs in mix mode never scan; remaining pins follow the matrix.
    wire logic [3:0] directMask = isDirect ? 4'hF : (isMix ? directSelect : 4'h0);
    wire logic [3:0] swNext  = (inDim && !isDirect) ? (pinOneHot & ~directMask) : 4'h0;
    wire logic [3:0] sinkNext = inDim ? (isDirect ? 4'hF : ~pinOneHot) : 4'h0;
    // Clamp in blank, or additionally while a sink's PWM is off in dimming.
    wire logic [3:0] clampRaw = inDim ? (clampTimingSel ? (sinkNext & ~pwmOn) : 4'h0) : 4'hF;
    wire logic [3:0] clampNext = clampDisable ? 4'h0 : clampRaw;
    // Code index: matrix LED anode curPin, index y = (sinkPin - curPin - 1) mod 4.
    logic [1:0] sinkPtr_q;
    wire logic [1:0] ledIdx = 2'(sinkPtr_q - curPin - 2'h1);
    wire logic [3:0] rdAddr = isDirect ? {2'h3, sinkPtr_q} : 4'(curPin * 3 + ledIdx);

    always_comb begin
        phase_d = phase_q;
        cnt_d   = cnt_q + 1'b1;
        slot_d  = slot_q;
        case (phase_q)
            lmsc_pkg::PH_DIM: begin
                if (dimDone) begin
                    phase_d = lmsc_pkg::PH_BLANK;
                    cnt_d   = '0;
                end
            end
            lmsc_pkg::PH_BLANK: begin
                if (blkDone) begin
                    phase_d = lmsc_pkg::PH_DIM;
                    cnt_d   = '0;
                    slot_d  = (isDirect || slot_q >= lastSlot) ? 2'h0 : slot_q + 2'h1;
                end
            end
            default: begin
                phase_d = lmsc_pkg::PH_DIM;
                cnt_d   = '0;
                slot_d  = 2'h0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q   <= lmsc_pkg::PH_DIM;
            cnt_q     <= '0;
            slot_q    <= 2'h0;
            sinkPtr_q <= 2'h0;
        end else begin
            phase_q   <= phase_d;
            cnt_q     <= cnt_d;
            slot_q    <= slot_d;
            sinkPtr_q <= sinkPtr_q + 2'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            scanSwitchEn_q  <= 4'h0;
            sinkEn_q        <= 4'h0;
            clampEn_q       <= 4'h0;
            clampLevel_q    <= 2'h0;
            fullScaleHigh_q <= lmsc_pkg::RANGE_RESET;
            activePin_q     <= 2'h0;
            frameStart_q    <= 1'b0;
        end else begin
            scanSwitchEn_q  <= swNext;
            sinkEn_q        <= sinkNext;
            clampEn_q       <= clampNext;
            clampLevel_q    <= clampLevelSel;
            fullScaleHigh_q <= globalRange;
            activePin_q     <= curPin;
            frameStart_q    <= blkDone && (isDirect || slot_q >= lastSlot);
        end
    end

    // Hysteresis between 97% and 101% of the target.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            passThrough_q <= 1'b0;
        end else if (outputPct >= PENTER) begin
            passThrough_q <= 1'b1;
        end else if (outputPct < PEXIT) begin
            passThrough_q <= 1'b0;
        end
    end

    lmsc_code_mem #(
        .DEPTH(16)
    ) u_mem (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .wrEn    (codeWrEn),
        .wrAddr  (codeWrAddr),
        .wrData  (codeWrData),
        .rdAddr  (rdAddr),
        .rdData_q(ledCode_q)
    );

    a_blank_dark: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (phase_q == lmsc_pkg::PH_BLANK) |=> (scanSwitchEn_q == 4'h0 && sinkEn_q == 4'h0))
        else $error("Outputs active during blank");
    a_one_switch: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $countones(scanSwitchEn_q) <= 1)
        else $error("More than one scan switch on");
    a_direct_noscan: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (isDirect && $stable(driveMode)) |=> scanSwitchEn_q == 4'h0)
        else $error("Scan switch in direct mode");
    a_dim_then_blank: assert property (@(posedge ref_clk) disable iff (!reset_n)
        dimDone |=> phase_q == lmsc_pkg::PH_BLANK)
        else $error("Dimming not followed by blank");
    a_blank_short: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ($rose(phase_q == lmsc_pkg::PH_BLANK) && !gapSel) |-> ##25 phase_q == lmsc_pkg::PH_DIM)
        else $error("Short blank length wrong");
    a_dim_24k: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ($rose(inDim) && !pwmFreqSel) |-> inDim [*8] ##1 (cnt_q == 12'd8))
        else $error("Dimming interval counting wrong");
    a_pass_enter: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (outputPct >= PENTER) |=> passThrough_q)
        else $error("Pass-through not entered");
    a_pass_exit: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (outputPct < PEXIT) |=> !passThrough_q)
        else $error("Pass-through not left");
    a_clamp_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clampDisable |=> clampEn_q == 4'h0)
        else $error("Clamp active while disabled");
    a_range_follow: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ##1 fullScaleHigh_q == $past(globalRange))
        else $error("Range bit not applied");

    c_frame: cover property (@(posedge ref_clk) disable iff (!reset_n) frameStart_q && driveMode == 3'h4);
    c_mix: cover property (@(posedge ref_clk) disable iff (!reset_n) isMix && scanSwitchEn_q != 4'h0);
    c_pass: cover property (@(posedge ref_clk) disable iff (!reset_n) $fell(passThrough_q));
endmodule : lmsc_scan_ctrl

// ===== test_led_matrix_scan_controller.sv
// Self-checking bench for the scan sequencer with the LED array model.
// Assumes a 25 MHz clock; dim and blank counts are worked out from the times.
`timescale 1ns/1ps
module test_led_matrix_scan_controller;
    logic        ref_clk, reset_n, pwmFreqSel, gapSel, clampDisable, clampTimingSel, globalRange;
    logic        codeWrEn, fullScaleHigh_q, passThrough_q, frameStart_q, pt;
    logic [1:0]  clampLevelSel, clampLevel_q, activePin_q;
    logic [2:0]  driveMode;
    logic [3:0]  directSelect, pwmOn, codeWrAddr, scanSwitchEn_q, sinkEn_q, clampEn_q;
    logic [7:0]  scanOrder, codeWrData, outputPct, ledCode_q;
    logic [11:0] ledLit;
    logic [31:0] seed = 32'h0001554F;
    logic [31:0] r;
    logic [7:0]  pctTab [6] = '{8'h65, 8'h63, 8'h61, 8'h60, 8'h64, 8'h65};
    int          err_total = 0;
    int          check_count = 0;
    int          fsCnt = 0;

    lmsc_scan_ctrl u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .driveMode(driveMode),
        .scanOrder(scanOrder), .directSelect(directSelect), .pwmFreqSel(pwmFreqSel), .gapSel(gapSel),
        .clampDisable(clampDisable), .clampTimingSel(clampTimingSel), .clampLevelSel(clampLevelSel),
        .globalRange(globalRange), .pwmOn(pwmOn), .codeWrEn(codeWrEn), .codeWrAddr(codeWrAddr),
        .codeWrData(codeWrData), .outputPct(outputPct), .scanSwitchEn_q(scanSwitchEn_q),
        .sinkEn_q(sinkEn_q), .clampEn_q(clampEn_q), .clampLevel_q(clampLevel_q),
        .fullScaleHigh_q(fullScaleHigh_q), .passThrough_q(passThrough_q), .activePin_q(activePin_q),
        .ledCode_q(ledCode_q), .frameStart_q(frameStart_q));
    lmsc_led_array u_arr (.scanSwitchEn(scanSwitchEn_q), .sinkEn(sinkEn_q), .ledLit(ledLit));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) if (frameStart_q === 1'b1) fsCnt++;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    // Reset is asserted while the mode fields are written, so each run starts on a frame edge.
    task automatic restart(input logic [2:0] m, input logic [7:0] o);
        @(negedge ref_clk);
        reset_n = 1'b0;
        driveMode = m;
        @(negedge ref_clk);
        chk("code reset", ledCode_q, 8'h80);
        chk("range reset", fullScaleHigh_q, 1'b0);
        scanOrder = o;
        @(negedge ref_clk);
        directSelect = 4'h8;
        reset_n = 1'b1;
    endtask : restart

    task automatic slot(input logic [1:0] ep, input logic mx, output int d, output int b);
        logic [3:0] sw;
        int n;
        sw = 4'h1 << ep;
        n = 0;
        d = 0;
        b = 0;
        while (scanSwitchEn_q === 4'h0 && n < 3000) begin
            n++;
            @(negedge ref_clk);
        end
        while (scanSwitchEn_q !== 4'h0 && d < 3000) begin
            chk("switch", scanSwitchEn_q, sw);
            chk("pin", activePin_q, ep);
            chk("code", ledCode_q, 8'h80);
            if (mx) chk("sink", sinkEn_q, 4'hF ^ sw);
            if (mx) chk("lit", ledLit, 12'h007 << (3 * ep));
            d++;
            @(negedge ref_clk);
        end
        while (scanSwitchEn_q === 4'h0 && b < 3000) begin
            chk("blank sink", sinkEn_q, 4'h0);
            chk("clamp", clampEn_q, clampDisable ? 4'h0 : 4'hF);
            b++;
            @(negedge ref_clk);
        end
    endtask : slot

    task automatic run(input logic [2:0] m, input logic [7:0] o);
        int d, b, sc, c0;
        sc = (m > 3'h4) ? m - 3'h4 : m;
        r = xs();
        pwmFreqSel = r[0];
        gapSel = r[1];
        clampDisable = r[2];
        clampTimingSel = r[3];
        restart(m, o);
        c0 = fsCnt;
        for (int fr = 0; fr < 2; fr++) begin
            for (int i = 0; i < sc; i++) begin
                slot(o[2*i +: 2], m < 3'h5, d, b);
                chk("dim len", d, pwmFreqSel ? 2100 : 1050);
                chk("blank len", b, gapSel ? 50 : 25);
            end
        end
        // The last frame pulse is counted one falling edge before the slot task returns; the extra edge is spare.
        @(negedge ref_clk);
        chk("frames", fsCnt - c0, 2);
        $display("test scan mode %0d done", m);
    endtask : run

    initial begin
        {driveMode, scanOrder, directSelect, pwmFreqSel, gapSel, clampDisable} = '0;
        {clampTimingSel, clampLevelSel, globalRange, codeWrEn, codeWrAddr, codeWrData} = '0;
        pwmOn = 4'hF;
        outputPct = 8'h64;
        reset_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        reset_n = 1'b1;
        run(3'h4, 8'hE4);
        for (int m = 1; m < 8; m++) begin
            r = xs();
            run(m[2:0], (m > 4) ? 8'hE4 : r[7:0]);
        end
        restart(3'h0, 8'hE4);
        repeat (3000) begin
            @(negedge ref_clk);
            chk("direct switch", scanSwitchEn_q, 4'h0);
        end
        $display("test direct mode done");
        pt = 1'b0;
        for (int i = 0; i < 40; i++) begin
            r = xs();
            outputPct = (i < 6) ? pctTab[i] : 8'(90 + r % 16);
            globalRange = r[8];
            clampLevelSel = r[10:9];
            pt = (outputPct >= 8'h65) ? 1'b1 : (outputPct < 8'h61) ? 1'b0 : pt;
            repeat (3) @(negedge ref_clk);
            chk("pass", passThrough_q, pt);
            chk("range", fullScaleHigh_q, globalRange);
            chk("level", clampLevel_q, clampLevelSel);
        end
        $display("test boost and range done");
        end_of_test();
    end

    initial begin
        repeat (95000) @(posedge ref_clk);
        err_total++;
        $display("Error watchdog expected done seen hang");
        end_of_test();
    end
endmodule : test_led_matrix_scan_controller
